// >>> hdl/utc_core.sv
// Full-duplex UART transceiver core with an AXI4-Lite register slave.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module utc_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             rx_error_irq,
  output logic             rx_end_irq,
  output logic             tx_enable_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              aw_held;
    logic [7:0]        aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        frame_control;
    logic [7:0]        option;
    logic [15:0]       baud_div;
    logic [7:0]        receive_data_buffer;
    logic              rx_unread;
    logic [7:0]        transmit_holding;
    logic              tx_pending;
    logic              parity_error_flag;
    logic              framing_error_flag;
    logic              overrun_flag;
    utc_pkg::utc_tx_e  tx_state;
    logic [11:0]       tx_shift;
    logic [3:0]        tx_left;
    logic [15:0]       tx_cnt;
    logic              tx_line;
    utc_pkg::utc_rx_e  rx_state;
    logic [15:0]       rx_cnt;
    logic [3:0]        rx_left;
    logic [9:0]        rx_shift;
    logic              rx_sync1;
    logic              rx_sync2;
    logic              rx_prev;
    logic              irq_err;
    logic              irq_end;
    logic              irq_tx;
  } utc_state_s;

  utc_state_s st;
  utc_state_s next_st;

  logic        power;
  logic        txe;
  logic        rxe;
  logic        msb_first;
  logic [1:0]  par_mode;
  logic        len8;
  logic        stop2;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  ch;
  logic        par_bit;
  logic [3:0]  dbits;
  logic [9:0]  rx_word;
  logic [7:0]  rx_char;
  logic        rx_par;
  logic        rx_stop;
  logic        pe;
  logic        fe;
  logic [3:0]  rx_total;

  assign power     = st.frame_control[utc_pkg::FC_POWER];
  assign txe       = st.frame_control[utc_pkg::FC_TXE];
  assign rxe       = st.frame_control[utc_pkg::FC_RXE];
  assign msb_first = st.frame_control[utc_pkg::FC_MSB];
  assign par_mode  = st.frame_control[utc_pkg::FC_PAR_HI:utc_pkg::FC_PAR_LO];
  assign len8      = st.frame_control[utc_pkg::FC_LEN8];
  assign stop2     = st.frame_control[utc_pkg::FC_STOP2];
  assign dbits     = len8 ? 4'h8 : 4'h7;
  // Data bits, optional parity, then the one stop bit that is checked.
  assign rx_total  = dbits + ((par_mode != utc_pkg::PAR_NONE) ? 4'h1 : 4'h0) + 4'h1;

  // ****************************************************************
  // Receive word decode
  // ****************************************************************
  // Bits enter at the top of rx_shift, so the last received bit sits in bit 9.
  always_comb begin
    rx_word = st.rx_shift >> (4'hA - rx_total);
    rx_stop = rx_word[rx_total - 4'h1];
    rx_par  = rx_word[dbits];
    rx_char = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(dbits)) begin
        if (msb_first) begin
          rx_char[7 - i] = rx_word[i];
        end else begin
          rx_char[i] = rx_word[i];
        end
      end
    end
    // The 8-bit MSB-first case lands fully in 7..0; 7-bit leaves bit 0 clear.
    pe = 1'b0;
    if (par_mode == utc_pkg::PAR_EVEN) begin
      pe = ^{rx_char, rx_par};
    end else if (par_mode == utc_pkg::PAR_ODD) begin
      pe = ~(^{rx_char, rx_par});
    end
    fe = ~rx_stop;
  end

  // ****************************************************************
  // Transmit frame build
  // ****************************************************************
  always_comb begin
    ch = st.transmit_holding;
    if (!len8) begin
      ch = msb_first ? {st.transmit_holding[7:1], 1'b0} : {1'b0, st.transmit_holding[6:0]};
    end
    unique case (par_mode)
      utc_pkg::PAR_EVEN: par_bit = ^ch;
      utc_pkg::PAR_ODD:  par_bit = ~(^ch);
      default:           par_bit = 1'b0;
    endcase
  end

  assign wr_go = st.aw_held && st.w_held && !st.bvalid;
  assign rd_go = s_axi_arvalid && !st.rvalid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0]  ord;
    logic [11:0] frm;
    logic [31:0] rd;
    logic        mid;
    ord = 8'h00;
    frm = 12'h000;
    rd  = 32'h0000_0000;
    mid = 1'b0;
    next_st = st;
    next_st.irq_err = 1'b0;
    next_st.irq_end = 1'b0;
    next_st.irq_tx  = 1'b0;
    next_st.rx_sync1 = serial_in_pin;
    next_st.rx_sync2 = st.rx_sync1;
    next_st.rx_prev  = st.rx_sync2;

    // Bus channels.
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = utc_pkg::AXI_OKAY;
      unique case (st.aw_addr)
        utc_pkg::ADDR_FRAME_CONTROL: begin
          if (st.w_strb[0]) begin
            next_st.frame_control = st.w_data[7:0];
          end
        end
        utc_pkg::ADDR_OPTION: begin
          if (st.w_strb[0]) begin
            next_st.option = st.w_data[7:0];
          end
        end
        utc_pkg::ADDR_BAUD_DIV: begin
          if (st.w_strb[0]) begin
            next_st.baud_div[7:0] = st.w_data[7:0];
          end
          if (st.w_strb[1]) begin
            next_st.baud_div[15:8] = st.w_data[15:8];
          end
        end
        utc_pkg::ADDR_LINE_STATUS: begin
          // Flags clear on a written zero only; a one leaves them as they are.
          if (st.w_strb[0]) begin
            next_st.parity_error_flag  = st.parity_error_flag & st.w_data[utc_pkg::ST_PE];
            next_st.framing_error_flag = st.framing_error_flag & st.w_data[utc_pkg::ST_FE];
            next_st.overrun_flag       = st.overrun_flag & st.w_data[utc_pkg::ST_OVE];
          end
        end
        utc_pkg::ADDR_TX_HOLD: begin
          if (st.w_strb[0]) begin
            next_st.transmit_holding = st.w_data[7:0];
            next_st.tx_pending = txe;
          end
        end
        utc_pkg::ADDR_RX_DATA: begin
          next_st.bresp = utc_pkg::AXI_SLVERR;
        end
        default: begin
          next_st.bresp = utc_pkg::AXI_SLVERR;
        end
      endcase
    end

    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = utc_pkg::AXI_OKAY;
      unique case (s_axi_araddr)
        utc_pkg::ADDR_FRAME_CONTROL: rd[7:0] = st.frame_control;
        utc_pkg::ADDR_OPTION:        rd[7:0] = st.option;
        utc_pkg::ADDR_BAUD_DIV:      rd[15:0] = st.baud_div;
        utc_pkg::ADDR_LINE_STATUS: begin
          rd[utc_pkg::ST_TSF] = (st.tx_state == utc_pkg::UTC_TX_SHIFT) || st.tx_pending;
          rd[utc_pkg::ST_PE]  = st.parity_error_flag;
          rd[utc_pkg::ST_FE]  = st.framing_error_flag;
          rd[utc_pkg::ST_OVE] = st.overrun_flag;
        end
        utc_pkg::ADDR_RX_DATA: begin
          rd[7:0] = st.receive_data_buffer;
          next_st.rx_unread = 1'b0;
        end
        utc_pkg::ADDR_TX_HOLD: rd[7:0] = st.transmit_holding;
        default: next_st.rresp = utc_pkg::AXI_SLVERR;
      endcase
      next_st.rdata = rd;
    end

    // Transmitter, independent of the receiver.
    unique case (st.tx_state)
      utc_pkg::UTC_TX_IDLE: begin
        next_st.tx_line = 1'b1;
        if (st.tx_pending && txe && power) begin
          for (int i = 0; i < 8; i++) begin
            ord[i] = msb_first ? ch[7 - i] : ch[i];
          end
          // Frame LSB first: start, data, parity, stops; spare tail is idle high.
          frm = 12'hFFF;
          frm[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (i < int'(dbits)) begin
              frm[i + 1] = ord[i];
            end
          end
          if (par_mode != utc_pkg::PAR_NONE) begin
            frm[dbits + 4'h1] = par_bit;
          end
          next_st.tx_shift = frm;
          next_st.tx_left  = 4'h1 + dbits + ((par_mode != utc_pkg::PAR_NONE) ? 4'h1 : 4'h0)
                             + (stop2 ? 4'h2 : 4'h1);
          next_st.tx_cnt   = st.baud_div;
          next_st.tx_line  = 1'b0;
          next_st.tx_pending = 1'b0;
          next_st.irq_tx   = 1'b1;
          next_st.tx_state = utc_pkg::UTC_TX_SHIFT;
        end
      end
      utc_pkg::UTC_TX_SHIFT: begin
        next_st.tx_line = st.tx_shift[0];
        if (st.tx_cnt > 16'h0001) begin
          next_st.tx_cnt = st.tx_cnt - 16'h0001;
        end else begin
          next_st.tx_cnt   = st.baud_div;
          next_st.tx_shift = {1'b1, st.tx_shift[11:1]};
          next_st.tx_left  = st.tx_left - 4'h1;
          next_st.tx_line  = st.tx_shift[1];
          if (st.tx_left == 4'h1) begin
            next_st.tx_line  = 1'b1;
            next_st.tx_state = utc_pkg::UTC_TX_IDLE;
          end
        end
      end
      default: next_st.tx_state = utc_pkg::UTC_TX_IDLE;
    endcase

    // Receiver.
    unique case (st.rx_state)
      utc_pkg::UTC_RX_IDLE: begin
        if (power && rxe && st.rx_prev && !st.rx_sync2) begin
          next_st.rx_cnt   = {1'b0, st.baud_div[15:1]};
          next_st.rx_state = utc_pkg::UTC_RX_START;
        end
      end
      utc_pkg::UTC_RX_START: begin
        if (st.rx_cnt > 16'h0001) begin
          next_st.rx_cnt = st.rx_cnt - 16'h0001;
        end else if (!st.rx_sync2) begin
          next_st.rx_cnt   = st.baud_div;
          next_st.rx_left  = rx_total;
          next_st.rx_state = utc_pkg::UTC_RX_SHIFT;
        end else begin
          next_st.rx_state = utc_pkg::UTC_RX_IDLE;
        end
      end
      utc_pkg::UTC_RX_SHIFT: begin
        if (st.rx_cnt > 16'h0001) begin
          next_st.rx_cnt = st.rx_cnt - 16'h0001;
        end else begin
          mid = 1'b1;
          next_st.rx_cnt   = st.baud_div;
          next_st.rx_shift = {st.rx_sync2, st.rx_shift[9:1]};
          next_st.rx_left  = st.rx_left - 4'h1;
        end
      end
      default: next_st.rx_state = utc_pkg::UTC_RX_IDLE;
    endcase
    if (!(power && rxe)) begin
      next_st.rx_state = utc_pkg::UTC_RX_IDLE;
    end

    // The last sample arrives this cycle; decode uses next_st.rx_shift through st
    // one cycle later, so completion waits in a zero-count slot.
    if (st.rx_state == utc_pkg::UTC_RX_SHIFT && st.rx_left == 4'h0 && power && rxe) begin
      next_st.rx_state = utc_pkg::UTC_RX_IDLE;
      if (st.rx_unread) begin
        next_st.overrun_flag = 1'b1;
        next_st.irq_err = 1'b1;
      end else begin
        next_st.receive_data_buffer = rx_char;
        next_st.rx_unread = 1'b1;
        if (pe || fe) begin
          next_st.parity_error_flag  = next_st.parity_error_flag | pe;
          next_st.framing_error_flag = next_st.framing_error_flag | fe;
          next_st.irq_err = 1'b1;
        end else begin
          next_st.irq_end = 1'b1;
        end
      end
    end else if (mid) begin
      next_st.rx_state = utc_pkg::UTC_RX_SHIFT;
    end

    if (!power) begin
      next_st.receive_data_buffer = utc_pkg::RST_DATA;
      next_st.rx_unread  = 1'b0;
      next_st.tx_state   = utc_pkg::UTC_TX_IDLE;
      next_st.tx_pending = 1'b0;
      next_st.tx_line    = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.frame_control       <= utc_pkg::RST_FRAME_CONTROL;
      st.option              <= utc_pkg::RST_OPTION;
      st.baud_div            <= utc_pkg::RST_BAUD_DIV;
      st.receive_data_buffer <= utc_pkg::RST_DATA;
      st.transmit_holding    <= utc_pkg::RST_DATA;
      st.tx_state            <= utc_pkg::UTC_TX_IDLE;
      st.rx_state            <= utc_pkg::UTC_RX_IDLE;
      st.tx_line             <= 1'b1;
      st.rx_sync1            <= 1'b1;
      st.rx_sync2            <= 1'b1;
      st.rx_prev             <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Separate lines let the system interrupt controller apply the fixed order.
  assign rx_error_irq   = st.irq_err;
  assign rx_end_irq     = st.irq_end;
  assign tx_enable_irq  = st.irq_tx;
  assign serial_out_pin = st.tx_line ^ (st.option[utc_pkg::OPT_TXINV] & power);
  assign s_axi_awready  = !st.aw_held;
  assign s_axi_wready   = !st.w_held;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = !st.rvalid;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;

endmodule

`default_nettype wire

// >>> inc/utc_pkg.sv
// Package holding register map, field positions, reset values and states of the transceiver.
package utc_pkg;

  // ****************************************************************
  // Register byte addresses (aligned 32-bit words)
  // ****************************************************************
  localparam logic [7:0] ADDR_FRAME_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_OPTION        = 8'h04;
  localparam logic [7:0] ADDR_LINE_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA       = 8'h0C;
  localparam logic [7:0] ADDR_TX_HOLD       = 8'h10;
  localparam logic [7:0] ADDR_BAUD_DIV      = 8'h14;

  // ****************************************************************
  // Frame control and option field positions
  // ****************************************************************
  localparam int FC_POWER  = 7;
  localparam int FC_TXE    = 6;
  localparam int FC_RXE    = 5;
  localparam int FC_MSB    = 4;
  localparam int FC_PAR_HI = 3;
  localparam int FC_PAR_LO = 2;
  localparam int FC_LEN8   = 1;
  localparam int FC_STOP2  = 0;
  localparam int OPT_TXINV = 0;

  // ****************************************************************
  // Line status field positions
  // ****************************************************************
  localparam int ST_TSF = 7;
  localparam int ST_PE  = 2;
  localparam int ST_FE  = 1;
  localparam int ST_OVE = 0;

  // ****************************************************************
  // Parity modes
  // ****************************************************************
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  RST_FRAME_CONTROL = 8'h1A;
  localparam logic [7:0]  RST_OPTION        = 8'h00;
  localparam logic [7:0]  RST_DATA          = 8'hFF;
  localparam logic [15:0] RST_BAUD_DIV      = 16'h0010;
  localparam logic [1:0]  AXI_OKAY          = 2'h0;
  localparam logic [1:0]  AXI_SLVERR        = 2'h2;

  typedef enum logic [1:0] {UTC_TX_IDLE, UTC_TX_SHIFT} utc_tx_e;
  typedef enum logic [1:0] {UTC_RX_IDLE, UTC_RX_START, UTC_RX_SHIFT} utc_rx_e;

endpackage

// >>> sim/utc_core_props.sv
// Concurrent checks on the ports of the transceiver core.
`timescale 1ns/1ps
`default_nettype none
module utc_core_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_pin,
  input wire logic        rx_error_irq,
  input wire logic        rx_end_irq,
  input wire logic        tx_enable_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] wr_addr;
  // The response of a write is judged against the latest address taken, even one taken while that response waits.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wr_addr <= s_axi_awaddr;
    end
  end
  chk_reset_idle: assert property ($rose(aresetn) |-> serial_out_pin && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  chk_irq_excl: assert property (!(rx_end_irq && rx_error_irq))
    else $error("end and error raised together");
  chk_end_once: assert property (rx_end_irq |=> !rx_end_irq && !rx_error_irq)
    else $error("second completion after end");
  chk_tx_start: assert property (tx_enable_irq |-> ##[0:2] $changed(serial_out_pin))
    else $error("no start bit after transmit interrupt");
  chk_rx_ro: assert property (s_axi_bvalid && wr_addr == utc_pkg::ADDR_RX_DATA
    |-> s_axi_bresp == utc_pkg::AXI_SLVERR)
    else $error("write to receive buffer accepted");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule
bind utc_core utc_core_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_out_pin(serial_out_pin),
  .rx_error_irq(rx_error_irq), .rx_end_irq(rx_end_irq), .tx_enable_irq(tx_enable_irq)
);
`default_nettype wire

// >>> sim/utc_remote.sv
// Remote serial end: sends frames to the core and samples the frames it sends.
`timescale 1ns/1ps
`default_nettype none
module utc_remote #(
  parameter int BAUD = 8
) (
  input  wire logic aclk,
  input  wire logic serial_out_pin,
  output var logic  line
);
  initial line = 1'b1;
  // Frame bit 0 is the start bit; the line idles high between frames.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (BAUD) @(posedge aclk);
    end
    line <= 1'b1;
  endtask
  // Sampling mid-bit keeps a one-cycle race at the bit edge harmless.
  task automatic get(input logic inv, input int n, output logic [11:0] f);
    int k;
    f = 12'hFFF;
    k = 0;
    while (serial_out_pin !== inv && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    repeat (BAUD / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BAUD) @(posedge aclk);
      f[i] = serial_out_pin ^ inv;
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/utc_core_tb_top.sv
// Self-checking testbench of the transceiver core.
`timescale 1ns/1ps
`default_nettype none
module utc_core_tb_top;
  localparam int BAUD = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_line;
  logic        awready, wready, bvalid, arready, rvalid, tx_line, rx_err, rx_end, tx_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, check_count;
  always #2 aclk = ~aclk;
  utc_core u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .rx_error_irq(rx_err),
    .rx_end_irq(rx_end), .tx_enable_irq(tx_irq)
  );
  utc_remote #(.BAUD(BAUD)) u_rem (.aclk(aclk), .serial_out_pin(tx_line), .line(rx_line));
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic guard(input int n);
    if (n > 300) begin
      failures++;
      give_verdict();
    end
  endtask
  // Handshakes are sampled at the falling edge, where nothing is moving.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ha, hw, hb;
    int n;
    n = 0;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) cmp("bresp", 32'(e), 32'(bresp));
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      guard(n++);
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] e, output logic [31:0] d);
    logic ha, hr;
    int n;
    n = 0;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      if (hr) cmp("rresp", 32'(e), 32'(rresp));
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      guard(n++);
    end
  endtask
  task automatic wait_irq(input int lim, output logic [2:0] s);
    s = 3'b000;
    for (int i = 0; i < lim && s == 3'b000; i++) begin
      @(negedge aclk);
      s = {rx_err, rx_end, tx_irq};
    end
  endtask
  function automatic logic [11:0] frame_of(input logic [7:0] fc, d, output int n);
    logic [11:0] f;
    logic        p;
    int          len;
    len = fc[utc_pkg::FC_LEN8] ? 8 : 7;
    f = 12'hFFE;
    p = 1'b0;
    for (int i = 0; i < len; i++) begin
      f[i+1] = fc[utc_pkg::FC_MSB] ? d[7-i] : d[i];
      p ^= f[i+1];
    end
    n = len + 1;
    if (fc[3:2] != utc_pkg::PAR_NONE) begin
      f[n] = (fc[3:2] == utc_pkg::PAR_EVEN) ? p : (fc[3:2] == utc_pkg::PAR_ODD) ? ~p : 1'b0;
      n++;
    end
    n += fc[utc_pkg::FC_STOP2] ? 2 : 1;
    return f;
  endfunction
  task automatic check_reset();
    logic [31:0] v;
    axi_rd(utc_pkg::ADDR_RX_DATA, utc_pkg::AXI_OKAY, v);
    cmp("rx_buffer", 32'h000000FF, v);
    axi_rd(utc_pkg::ADDR_TX_HOLD, utc_pkg::AXI_OKAY, v);
    cmp("tx_holding", 32'h000000FF, v);
    axi_rd(8'h18, utc_pkg::AXI_SLVERR, v);
    axi_wr(utc_pkg::ADDR_RX_DATA, 32'h00000012, utc_pkg::AXI_SLVERR);
    axi_rd(utc_pkg::ADDR_RX_DATA, utc_pkg::AXI_OKAY, v);
    cmp("rx_buffer", 32'h000000FF, v);
  endtask
  task automatic check_tx();
    logic [11:0] f, g, h;
    logic [31:0] v;
    logic [7:0]  fc, d;
    logic [2:0]  s;
    int          n;
    axi_wr(utc_pkg::ADDR_FRAME_CONTROL, 32'h00000080, utc_pkg::AXI_OKAY);
    repeat (3) @(posedge aclk);
    cmp("idle_line", 32'h1, 32'(tx_line));
    for (int k = 0; k < 4; k++) begin
      fc = {3'b110, k[1], k[1:0], k[0], k[1] & k[0]};
      d = 8'hA5 ^ 8'(k * 17);
      f = frame_of(fc, d, n);
      axi_wr(utc_pkg::ADDR_OPTION, {31'h0, k == 2}, utc_pkg::AXI_OKAY);
      axi_wr(utc_pkg::ADDR_FRAME_CONTROL, {24'h0, fc}, utc_pkg::AXI_OKAY);
      fork
        u_rem.get(k == 2, n, g);
        axi_wr(utc_pkg::ADDR_TX_HOLD, {24'h0, d}, utc_pkg::AXI_OKAY);
        wait_irq(200, s);
      join
      cmp("tx_irq", 32'h1, 32'(s));
      cmp("tx_frame", 32'(f), 32'(g));
      repeat (BAUD) @(posedge aclk);
      axi_rd(utc_pkg::ADDR_LINE_STATUS, utc_pkg::AXI_OKAY, v);
      cmp("tx_busy", 32'h0, 32'(v[7]));
      axi_rd(utc_pkg::ADDR_TX_HOLD, utc_pkg::AXI_OKAY, v);
      cmp("tx_holding", 32'(d), v);
    end
    // The next character goes in on the transmit interrupt, mid-frame.
    fork
      begin
        u_rem.get(1'b0, n, g);
        u_rem.get(1'b0, n, h);
      end
      begin
        axi_wr(utc_pkg::ADDR_TX_HOLD, {24'h0, d}, utc_pkg::AXI_OKAY);
        wait_irq(200, s);
        axi_wr(utc_pkg::ADDR_TX_HOLD, {24'h0, d}, utc_pkg::AXI_OKAY);
      end
    join
    cmp("tx_irq", 32'h1, 32'(s));
    cmp("tx_frame", 32'(f), 32'(g));
    cmp("tx_frame", 32'(f), 32'(h));
  endtask
  task automatic rx_case(input logic [7:0] fc, d, input logic [11:0] flip, input logic [2:0] ei,
                         input logic [2:0] est, input logic rd, chk, input logic [7:0] eb);
    logic [11:0] f;
    logic [31:0] v;
    logic [2:0]  s;
    int          n;
    f = frame_of(fc, d, n);
    axi_wr(utc_pkg::ADDR_FRAME_CONTROL, {24'h0, fc}, utc_pkg::AXI_OKAY);
    fork
      u_rem.send(f ^ flip, n);
      wait_irq(BAUD * 14, s);
    join
    cmp("rx_irq", 32'(ei), 32'(s));
    if (rd) axi_rd(utc_pkg::ADDR_RX_DATA, utc_pkg::AXI_OKAY, v);
    if (chk) cmp("rx_buffer", 32'(eb), v);
    axi_rd(utc_pkg::ADDR_LINE_STATUS, utc_pkg::AXI_OKAY, v);
    cmp("rx_status", 32'(est), 32'(v[2:0]));
    axi_wr(utc_pkg::ADDR_LINE_STATUS, 32'h0, utc_pkg::AXI_OKAY);
  endtask
  task automatic check_rx();
    logic [7:0]  fc, d, eb;
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      fc = {3'b101, k[1], k[1:0], k[0], k[1] & k[0]};
      d = 8'h5A ^ 8'(k * 51);
      eb = fc[1] ? d : (fc[4] ? {d[7:1], 1'b0} : {1'b0, d[6:0]});
      rx_case(fc, d, 12'h000, 3'b010, 3'b000, 1'b1, 1'b1, eb);
    end
    rx_case(8'hAE, 8'h96, 12'h200, 3'b100, 3'b100, 1'b1, 1'b0, 8'h00);
    rx_case(8'hAE, 8'h96, 12'h400, 3'b100, 3'b010, 1'b1, 1'b0, 8'h00);
    rx_case(8'hAE, 8'h3C, 12'h000, 3'b010, 3'b000, 1'b0, 1'b0, 8'h00);
    rx_case(8'hAE, 8'hC3, 12'h000, 3'b100, 3'b001, 1'b1, 1'b1, 8'h3C);
    rx_case(8'h82, 8'h11, 12'h000, 3'b000, 3'b000, 1'b0, 1'b0, 8'h00);
    axi_wr(utc_pkg::ADDR_FRAME_CONTROL, 32'h0, utc_pkg::AXI_OKAY);
    axi_rd(utc_pkg::ADDR_RX_DATA, utc_pkg::AXI_OKAY, v);
    cmp("rx_buffer", 32'h000000FF, v);
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check_reset();
    axi_wr(utc_pkg::ADDR_BAUD_DIV, 32'(BAUD), utc_pkg::AXI_OKAY);
    check_tx();
    check_rx();
    give_verdict();
  end
endmodule
`default_nettype wire
